// >>> rtl/ref_clock_input_loss_monitor.sv
// reference clock inputs, pre-dividers, switch priority and loss-of-signal monitor
`include "ref_clk_defs.svh"
module ref_clock_input_loss_monitor
    import ref_clk_pkg::*;
(
    input  wire logic                    sys_clk,
    input  wire logic                    rst_n,
    input  wire ref_clk_pkg::avl_req_t   avlReq,
    output ref_clk_pkg::avl_rsp_t        avlRsp,
    input  wire logic [1:0]              padPin,
    input  wire logic                    freqStatus,
    input  wire logic [3:0]              peerUnusable,
    input  wire logic [5:0]              peerRanks,
    output logic                         refClockPulse,
    output logic                         padClockPulse,
    output logic [1:0]                   selectedInput,
    output logic                         selectedValid,
    output logic                         inputUnusable
);
    import ref_clk_pkg::*;

    logic [15:0] padConfig;
    logic [31:0] predivConfig;
    logic [15:0] lossWindow;
    logic [15:0] expectedCount;
    logic [31:0] lossMargins;
    logic [7:0]  qualifyCfg;
    logic [7:0]  monCtrl;
    logic        lossStatus;
    logic        lossSticky;
    logic        overFlag;
    logic [3:0]  lossCounter;
    bus_state_t  busState;
    logic [1:0]  pinMeta;
    logic [1:0]  pinSync;
    logic [1:0]  pinLast;
    logic        monEdge;
    logic        padTick;
    logic        winPulse;
    logic [15:0] periodCount;
    logic [3:0]  goodRun;
    logic [3:0]  badRun;
    logic        lossRise;
    logic        monHeld;
    logic        wrHit;
    logic [31:0] next_readdata;
    logic [31:0] readData;
    logic [16:0] countDiff;
    logic        windowAccept;
    logic        windowReject;

    // --------------------------------
    // pin synchroniser
    // --------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            pinMeta <= 2'h0;
            pinSync <= 2'h0;
            pinLast <= 2'h0;
        end
        else
        begin
            pinMeta <= padPin;
            pinSync <= pinMeta;
            pinLast <= pinSync;
        end
    end

    always_comb
    begin
        case (padConfig[2:1])
            2'h0:    monEdge = pinSync[0] & ~pinSync[1] & ~(pinLast[0] & ~pinLast[1]);
            2'h2:    monEdge = pinSync[1] & ~pinLast[1];
            default: monEdge = pinSync[0] & ~pinLast[0];
        endcase
    end

    // --------------------------------
    // pad and pre-dividers
    // --------------------------------
    logic padDivOut;
    logic padEdge;
    logic predivOut;

    assign padEdge = monEdge & padConfig[`POS_PAD_ENABLE];

    clk_divider padDiv (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .tick    (padEdge),
        .run_n   (padConfig[`POS_PAD_RUN_N] | (padConfig[14:10] == 5'h00)),
        .ratio   ({15'h0000, padConfig[14:10]}),
        .pulse   (padDivOut)
    );

    assign padTick = (padConfig[14:10] == 5'h00) ? padEdge : padDivOut;

    clk_divider preDiv (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .tick    (padTick),
        .run_n   (predivConfig[`POS_PREDIV_RUN_N] | predivConfig[`POS_PREDIV_BYPASS]),
        .ratio   (predivConfig[19:0]),
        .pulse   (predivOut)
    );

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            refClockPulse <= 1'b0;
            padClockPulse <= 1'b0;
        end
        else
        begin
            padClockPulse <= padTick;
            refClockPulse <= predivConfig[`POS_PREDIV_BYPASS] ? padTick : predivOut;
        end
    end

    // --------------------------------
    // loss monitor window
    // --------------------------------
    assign monHeld = monCtrl[`POS_MON_SRST] | monCtrl[`POS_MON_GATE];

    clk_divider winDiv (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .tick    (padEdge),
        .run_n   (~monHeld),
        .ratio   ({15'h0000, lossWindow[4:0]}),
        .pulse   (winPulse)
    );

    always_comb
    begin
        countDiff = (periodCount >= expectedCount)
            ? {1'b0, periodCount - expectedCount}
            : {1'b0, expectedCount - periodCount};
        windowAccept = countDiff <= {2'b00, lossMargins[30:16]};
        windowReject = countDiff >  {2'b00, lossMargins[14:0]};
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n || monHeld || winPulse)
        begin
            periodCount <= 16'h0001;
        end
        else if (periodCount != 16'hffff)
        begin
            periodCount <= periodCount + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n || monHeld)
        begin
            goodRun    <= 4'h0;
            badRun     <= 4'h0;
            lossStatus <= 1'b1;
        end
        else if (expectedCount == 16'h0000)
        begin
            lossStatus <= 1'b1;
            goodRun    <= 4'h0;
            badRun     <= 4'h0;
        end
        else if (winPulse)
        begin
            if (windowReject)
            begin
                goodRun <= 4'h0;
                if (badRun + 4'h1 >= qualifyCfg[3:0])
                begin
                    lossStatus <= 1'b1;
                    badRun     <= 4'h0;
                end
                else
                begin
                    badRun <= badRun + 4'h1;
                end
            end
            else if (windowAccept)
            begin
                if (goodRun + 4'h1 >= qualifyCfg[7:4])
                begin
                    lossStatus <= 1'b0;
                    goodRun    <= 4'h0;
                    badRun     <= 4'h0;
                end
                else
                begin
                    goodRun <= goodRun + 4'h1;
                end
            end
        end
    end

    logic lossLast;
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            lossLast <= 1'b1;
        end
        else
        begin
            lossLast <= lossStatus;
        end
    end
    assign lossRise = lossStatus & ~lossLast;

    // --------------------------------
    // events and counter
    // --------------------------------
    assign wrHit = (busState == BUS_ACK) & avlReq.write;

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            lossSticky <= 1'b1;
        end
        else if (lossStatus)
        begin
            lossSticky <= 1'b1;
        end
        else if (wrHit && avlReq.address == `OFS_LOSS_EVENTS && avlReq.writedata[0])
        begin
            lossSticky <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            overFlag <= 1'b0;
        end
        else if (lossCounter > lossWindow[11:8])
        begin
            overFlag <= 1'b1;
        end
        else if (wrHit && avlReq.address == `OFS_LOSS_EVENTS && avlReq.writedata[1])
        begin
            overFlag <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            lossCounter <= 4'h0;
        end
        else if (wrHit && avlReq.address == `OFS_LOSS_COUNTER && !monHeld)
        begin
            lossCounter <= avlReq.writedata[3:0];
        end
        else if (lossRise && !monHeld && lossCounter != 4'hf)
        begin
            lossCounter <= lossCounter + 4'h1;
        end
    end

    // --------------------------------
    // unusable and selection
    // --------------------------------
    // or of masked loss and freq terms, select block and pad disable
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            inputUnusable <= 1'b1;
        end
        else
        begin
            inputUnusable <= (lossStatus & ~lossWindow[`POS_LOSS_MASK])
                | (freqStatus & ~monCtrl[`POS_FREQ_MASK])
                | lossWindow[`POS_SELECT_BLOCK]
                | ~padConfig[`POS_PAD_ENABLE];
        end
    end

    logic [1:0] rankOf [`NUM_INPUTS];
    logic [3:0] usable;
    always_comb
    begin
        rankOf[0] = predivConfig[25:24];
        rankOf[1] = peerRanks[1:0];
        rankOf[2] = peerRanks[3:2];
        rankOf[3] = peerRanks[5:4];
        usable    = ~{peerUnusable[3:1], inputUnusable};
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            selectedInput <= 2'h0;
            selectedValid <= 1'b0;
        end
        else
        begin
            selectedValid <= |usable;
            selectedInput <= 2'h0;
            for (int r = 3; r >= 0; r--)
            begin
                for (int i = 3; i >= 0; i--)
                begin
                    if (usable[i] && rankOf[i] == 2'(r))
                    begin
                        selectedInput <= 2'(i);
                    end
                end
            end
        end
    end

    // --------------------------------
    // avalon slave
    // --------------------------------
    always_comb
    begin
        case (avlReq.address)
            `OFS_PAD_CONFIG:    next_readdata = {16'h0000, padConfig};
            `OFS_PREDIV_CONFIG: next_readdata = predivConfig & 32'h035f_ffff;
            `OFS_LOSS_WINDOW:   next_readdata = {16'h0000, lossWindow & 16'h0f7f};
            `OFS_LOSS_NOMINAL:  next_readdata = {16'h0000, expectedCount};
            `OFS_LOSS_MARGINS:  next_readdata = lossMargins & 32'h7fff_7fff;
            `OFS_LOSS_QUALIFY:  next_readdata = {24'h000000, qualifyCfg};
            `OFS_LOSS_STATUS:   next_readdata = {30'h0, inputUnusable, lossStatus};
            `OFS_LOSS_EVENTS:   next_readdata = {30'h0, overFlag, lossSticky};
            `OFS_LOSS_COUNTER:  next_readdata = {28'h0, lossCounter};
            `OFS_MONITOR_CTRL:  next_readdata = {29'h0, monCtrl[2:0]};
            default:            next_readdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            busState <= BUS_IDLE;
            readData <= 32'h0000_0000;
        end
        else
        begin
            case (busState)
                BUS_IDLE:
                begin
                    if (avlReq.read || avlReq.write)
                    begin
                        busState <= BUS_ACK;
                        readData <= next_readdata;
                    end
                end
                BUS_ACK:  busState <= BUS_DONE;
                BUS_DONE: busState <= BUS_IDLE;
                default:  busState <= BUS_IDLE;
            endcase
        end
    end
    assign avlRsp.waitrequest = (busState != BUS_ACK);
    assign avlRsp.readdata    = readData;

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            padConfig     <= `RST_PAD_CONFIG;
            predivConfig  <= `RST_PREDIV_CONFIG;
            lossWindow    <= 16'h0000;
            expectedCount <= 16'h0000;
            lossMargins   <= 32'h0000_0000;
            qualifyCfg    <= `RST_LOSS_QUALIFY;
            monCtrl       <= 8'h00;
        end
        else if (wrHit)
        begin
            case (avlReq.address)
                `OFS_PAD_CONFIG:    padConfig     <= avlReq.writedata[15:0];
                `OFS_PREDIV_CONFIG: predivConfig  <= avlReq.writedata;
                `OFS_LOSS_WINDOW:   lossWindow    <= avlReq.writedata[15:0];
                `OFS_LOSS_NOMINAL:  expectedCount <= avlReq.writedata[15:0];
                `OFS_LOSS_MARGINS:  lossMargins   <= avlReq.writedata;
                `OFS_LOSS_QUALIFY:  qualifyCfg    <= avlReq.writedata[7:0];
                `OFS_MONITOR_CTRL:  monCtrl       <= avlReq.writedata[7:0];
                default:            monCtrl       <= monCtrl;
            endcase
        end
    end

    // --------------------------------
    // assertions
    // --------------------------------
    // over flag follows counter
    a_over_flag_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
        lossCounter > lossWindow[11:8] |=> overFlag)
        else $error("over flag not set");
    a_sticky_loss: assert property (@(posedge sys_clk) disable iff (!rst_n)
        lossStatus |=> lossSticky)
        else $error("sticky flag lost during loss");
    a_disabled_loss: assert property (@(posedge sys_clk) disable iff (!rst_n)
        expectedCount == 16'h0000 |=> lossStatus)
        else $error("disabled monitor not in loss");
    a_block_unusable: assert property (@(posedge sys_clk) disable iff (!rst_n)
        lossWindow[`POS_SELECT_BLOCK] |=> inputUnusable)
        else $error("blocked input usable");
    a_counter_saturate: assert property (@(posedge sys_clk) disable iff (!rst_n)
        lossCounter == 4'hf && !wrHit |=> lossCounter == 4'hf)
        else $error("counter wrapped");
    a_counter_held: assert property (@(posedge sys_clk) disable iff (!rst_n)
        monHeld |=> $stable(lossCounter))
        else $error("counter changed while held");
    a_unusable_cause: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !lossStatus && !freqStatus && !lossWindow[6] && padConfig[3] |=> !inputUnusable)
        else $error("unusable without cause");
    a_bypass_pass: assert property (@(posedge sys_clk) disable iff (!rst_n)
        predivConfig[`POS_PREDIV_BYPASS] && padTick |=> refClockPulse)
        else $error("bypass lost edge");
    sequence s_accept_last;
        winPulse && windowAccept && !windowReject;
    endsequence
    sequence s_run_full;
        (goodRun + 4'h1 >= qualifyCfg[7:4]) && !monHeld && (expectedCount != 16'h0000);
    endsequence
    a_qualify_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_accept_last ##0 s_run_full |=> !lossStatus)
        else $error("qualified run kept loss");
endmodule

// >>> common/ref_clk_defs.svh
// offsets, field positions, reset values and input count of the reference clock input block
`ifndef REF_CLK_DEFS_SVH
`define REF_CLK_DEFS_SVH

`define OFS_PAD_CONFIG      8'h00
`define OFS_PREDIV_CONFIG   8'h04
`define OFS_LOSS_WINDOW     8'h08
`define OFS_LOSS_NOMINAL    8'h0c
`define OFS_LOSS_MARGINS    8'h10
`define OFS_LOSS_QUALIFY    8'h14
`define OFS_LOSS_STATUS     8'h18
`define OFS_LOSS_EVENTS     8'h1c
`define OFS_LOSS_COUNTER    8'h20
`define OFS_MONITOR_CTRL    8'h24

`define RST_PAD_CONFIG      16'h8001
`define RST_PREDIV_CONFIG   32'h0050_0000
`define RST_LOSS_QUALIFY    8'h44

`define POS_PAD_RUN_N       15
`define POS_PAD_ENABLE      3
`define POS_PREDIV_RUN_N    22
`define POS_PREDIV_BYPASS   20
`define POS_SELECT_BLOCK    6
`define POS_LOSS_MASK       5
`define POS_FREQ_MASK       2
`define POS_MON_GATE        1
`define POS_MON_SRST        0

`define NUM_INPUTS          4
`endif

// >>> common/ref_clk_pkg.sv
// types of the reference clock input block
package ref_clk_pkg;
    typedef struct packed {
        logic        write;
        logic        read;
        logic [7:0]  address;
        logic [31:0] writedata;
    } avl_req_t;

    typedef struct packed {
        logic        waitrequest;
        logic [31:0] readdata;
    } avl_rsp_t;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_ACK  = 3'b010,
        BUS_DONE = 3'b100
    } bus_state_t;
endpackage

// >>> rtl/clk_divider.sv
// programmable clock divider that emits one-cycle enable pulses
`include "ref_clk_defs.svh"
module clk_divider
    import ref_clk_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        tick,
    input  wire logic        run_n,
    input  wire logic [19:0] ratio,
    output logic             pulse
);
    logic [19:0] count;

    // --------------------------------
    // divide counter
    // --------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n || !run_n)
        begin
            count <= 20'h00000;
            pulse <= 1'b0;
        end
        else if (tick)
        begin
            if (ratio <= 20'h00001 || count >= ratio - 20'h00001)
            begin
                count <= 20'h00000;
                pulse <= 1'b1;
            end
            else
            begin
                count <= count + 20'h00001;
                pulse <= 1'b0;
            end
        end
        else
        begin
            pulse <= 1'b0;
        end
    end
endmodule

// >>> bench/ref_clk_source.sv
// external reference clock source driving the two pad pins
module ref_clk_source
(
    input  wire logic [0:0] sys_clk,
    input  wire logic [7:0] halfPeriod,
    input  wire logic [1:0] pinsActive,
    output logic [1:0]      padPin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] phaseCount = 8'h00;
    logic       level      = 1'b0;
    // half period of eight or more keeps rate low
    always @(posedge sys_clk)
    begin
        if (phaseCount + 8'h01 >= halfPeriod)
        begin
            phaseCount <= 8'h00;
            level      <= ~level;
        end
        else
            phaseCount <= phaseCount + 8'h01;
    end
    // idle pin stands low, negative pin inverse
    assign padPin = {pinsActive[1] & ~level, pinsActive[0] & level};
endmodule

// >>> bench/tb_ref_clock_input_loss_monitor.sv
// self-checking bench of the reference clock input and loss monitor
`include "ref_clk_defs.svh"
module tb_ref_clock_input_loss_monitor;
    timeunit 1ns;
    timeprecision 1ps;
    import ref_clk_pkg::*;
    logic        sys_clk      = 1'b0;
    logic        rst_n        = 1'b0;
    avl_req_t    avlReq       = '0;
    avl_rsp_t    avlRsp;
    logic [1:0]  padPin;
    logic        freqStatus   = 1'b0;
    logic [3:0]  peerUnusable = 4'hf;
    logic [5:0]  peerRanks    = 6'h00;
    logic        refClockPulse;
    logic        padClockPulse;
    logic [1:0]  selectedInput;
    logic        selectedValid;
    logic        inputUnusable;
    logic [7:0]  halfPeriod   = 8'h08;
    logic [1:0]  pinsActive   = 2'b11;
    logic [31:0] rdata;
    int          n_errors     = 0;
    int          tests_run    = 0;
    int          i;
    int          nRef;
    int          nPad;
    logic [15:0] padT [10] = '{16'h8009, 16'h8009, 16'h8009, 16'h8009, 16'h8809,
                               16'h0809, 16'h0009, 16'h800d, 16'h800b, 16'h800f};
    logic [31:0] preT [10] = '{32'h0050_0000, 32'h0040_0002, 32'h0000_0002, 32'h0010_0000,
                               32'h0050_0000, 32'h0050_0000, 32'h0050_0000, 32'h0050_0000,
                               32'h0050_0000, 32'h0050_0000};
    logic [1:0]  pinT [10] = '{2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h1, 2'h1, 2'h1};
    logic [15:0] limT [10] = '{16'h9b9b, 16'h469b, 16'h009b, 16'h9b9b, 16'h0b46,
                               16'h0b00, 16'h0b9b, 16'h0b00, 16'h0b9b, 16'h0b9b};

    always #2 sys_clk = ~sys_clk;

    ref_clock_input_loss_monitor ref_clock_input_loss_monitor_inst (
        .sys_clk(sys_clk), .rst_n(rst_n), .avlReq(avlReq), .avlRsp(avlRsp),
        .padPin(padPin), .freqStatus(freqStatus), .peerUnusable(peerUnusable),
        .peerRanks(peerRanks), .refClockPulse(refClockPulse),
        .padClockPulse(padClockPulse), .selectedInput(selectedInput),
        .selectedValid(selectedValid), .inputUnusable(inputUnusable));

    ref_clk_source ref_clk_source_inst (
        .sys_clk(sys_clk), .halfPeriod(halfPeriod), .pinsActive(pinsActive),
        .padPin(padPin));

    task summarize;
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task bus(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
        int k;
        k = 0;
        @(posedge sys_clk);
        avlReq <= '{wr, ~wr, addr, wdata};
        do
        begin
            @(posedge sys_clk);
            k++;
        end
        while (avlRsp.waitrequest !== 1'b0 && k < 20);
        rdata = avlRsp.readdata;
        avlReq <= '0;
        @(posedge sys_clk);
        if (k >= 20)
        begin
            n_errors++;
            $display("Error waitrequest expected 0 seen 1");
            summarize();
        end
    endtask

    task wr(input logic [7:0] addr, input logic [31:0] wdata);
        bus(1'b1, addr, wdata);
    endtask

    task rd(input string what, input logic [7:0] addr, input logic [31:0] exp);
        bus(1'b0, addr, 32'h0000_0000);
        check(what, exp, rdata);
    endtask

    task wait_loss(input logic exp);
        int k;
        for (k = 0; k < 100; k++)
        begin
            bus(1'b0, `OFS_LOSS_STATUS, 32'h0000_0000);
            if (rdata[0] === exp)
                break;
        end
        check("loss status", {31'h0, exp}, {31'h0, rdata[0]});
        if (k == 100)
            summarize();
    endtask

    task measure(input int cycles);
        nRef = 0;
        nPad = 0;
        repeat (cycles)
        begin
            @(posedge sys_clk);
            nRef += (refClockPulse === 1'b1);
            nPad += (padClockPulse === 1'b1);
        end
    endtask

    initial
    begin
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        check("unusable pin", 32'h1, {31'h0, inputUnusable});
        rd("pad config", `OFS_PAD_CONFIG, 32'h0000_8001);
        rd("prediv config", `OFS_PREDIV_CONFIG, 32'h0050_0000);
        rd("qualify", `OFS_LOSS_QUALIFY, 32'h0000_0044);
        rd("status", `OFS_LOSS_STATUS, 32'h0000_0003);
        rd("events", `OFS_LOSS_EVENTS, 32'h0000_0001);
        rd("counter", `OFS_LOSS_COUNTER, 32'h0000_0000);
        rd("unmapped", 8'h3c, 32'h0000_0000);
        $display("test reset done");
        wr(`OFS_MONITOR_CTRL, 32'h1);
        wr(`OFS_LOSS_WINDOW, 32'h0000_0001);
        wr(`OFS_LOSS_NOMINAL, 32'h0000_0010);
        wr(`OFS_LOSS_MARGINS, 32'h0002_0004);
        wr(`OFS_PAD_CONFIG, 32'h0000_8009);
        wr(`OFS_MONITOR_CTRL, 32'h0);
        wait_loss(1'b0);
        rd("status", `OFS_LOSS_STATUS, 32'h0);
        wr(`OFS_LOSS_EVENTS, 32'h3);
        rd("events", `OFS_LOSS_EVENTS, 32'h0);
        $display("test qualify done");
        halfPeriod <= 8'h04;
        wait_loss(1'b1);
        rd("counter", `OFS_LOSS_COUNTER, 32'h1);
        wr(`OFS_LOSS_EVENTS, 32'h3);
        rd("events", `OFS_LOSS_EVENTS, 32'h3);
        halfPeriod <= 8'h08;
        wait_loss(1'b0);
        wr(`OFS_LOSS_EVENTS, 32'h3);
        rd("events", `OFS_LOSS_EVENTS, 32'h2);
        wr(`OFS_LOSS_COUNTER, 32'h0);
        wr(`OFS_LOSS_EVENTS, 32'h3);
        rd("events", `OFS_LOSS_EVENTS, 32'h0);
        $display("test loss done");
        wr(`OFS_MONITOR_CTRL, 32'h2);
        wr(`OFS_LOSS_COUNTER, 32'h5);
        rd("gated counter", `OFS_LOSS_COUNTER, 32'h0);
        wr(`OFS_MONITOR_CTRL, 32'h1);
        wr(`OFS_LOSS_COUNTER, 32'h5);
        rd("reset counter", `OFS_LOSS_COUNTER, 32'h0);
        wr(`OFS_MONITOR_CTRL, 32'h0);
        wait_loss(1'b0);
        wr(`OFS_LOSS_COUNTER, 32'hf);
        rd("counter", `OFS_LOSS_COUNTER, 32'hf);
        wr(`OFS_LOSS_COUNTER, 32'h0);
        $display("test counter done");
        freqStatus <= 1'b1;
        rd("status", `OFS_LOSS_STATUS, 32'h2);
        wr(`OFS_MONITOR_CTRL, 32'h4);
        rd("status", `OFS_LOSS_STATUS, 32'h0);
        freqStatus <= 1'b0;
        wr(`OFS_MONITOR_CTRL, 32'h0);
        wr(`OFS_LOSS_WINDOW, 32'h0000_0041);
        rd("status", `OFS_LOSS_STATUS, 32'h2);
        check("unusable pin", 32'h1, {31'h0, inputUnusable});
        check("valid", 32'h0, {31'h0, selectedValid});
        wr(`OFS_LOSS_WINDOW, 32'h0000_0001);
        halfPeriod <= 8'h04;
        wait_loss(1'b1);
        wr(`OFS_LOSS_WINDOW, 32'h0000_0021);
        rd("status", `OFS_LOSS_STATUS, 32'h1);
        wr(`OFS_LOSS_WINDOW, 32'h0000_0001);
        halfPeriod <= 8'h08;
        wait_loss(1'b0);
        $display("test masks done");
        peerUnusable <= 4'h0;
        repeat (4) @(posedge sys_clk);
        check("selected", 32'h0, {30'h0, selectedInput});
        wr(`OFS_PREDIV_CONFIG, 32'h0250_0000);
        peerRanks <= 6'b11_01_01;
        repeat (4) @(posedge sys_clk);
        check("selected", 32'h1, {30'h0, selectedInput});
        peerUnusable <= 4'h2;
        repeat (4) @(posedge sys_clk);
        check("selected", 32'h2, {30'h0, selectedInput});
        peerUnusable <= 4'he;
        repeat (4) @(posedge sys_clk);
        check("selected", 32'h0, {30'h0, selectedInput});
        check("valid", 32'h1, {31'h0, selectedValid});
        $display("test priority done");
        for (i = 0; i < 10; i++)
        begin
            wr(`OFS_PAD_CONFIG, {16'h0, padT[i]});
            wr(`OFS_PREDIV_CONFIG, preT[i]);
            pinsActive <= pinT[i];
            repeat (40) @(posedge sys_clk);
            measure(160);
            check("ref pulses", 32'h1, (nRef >= limT[i][15:12] && nRef <= limT[i][11:8]));
            check("pad pulses", 32'h1, (nPad >= limT[i][7:4] && nPad <= limT[i][3:0]));
        end
        pinsActive <= 2'b11;
        wr(`OFS_PAD_CONFIG, 32'h0000_8001);
        repeat (4) @(posedge sys_clk);
        check("unusable pin", 32'h1, {31'h0, inputUnusable});
        wr(`OFS_PAD_CONFIG, 32'h0000_8009);
        $display("test dividers done");
        wr(`OFS_LOSS_NOMINAL, 32'h0);
        wait_loss(1'b1);
        wr(`OFS_LOSS_WINDOW, 32'h0000_0021);
        rd("status", `OFS_LOSS_STATUS, 32'h1);
        $display("test disable done");
        summarize();
    end
endmodule
